// ===== include/btq_consts.svh
`ifndef BTQ_CONSTS_SVH
`define BTQ_CONSTS_SVH

// register byte offsets
`define BTQ_OFF_CTRL 8'h00
`define BTQ_OFF_STAT 8'h04
`define BTQ_OFF_C_ADDR 8'h08
`define BTQ_OFF_C_MASK 8'h0c
`define BTQ_OFF_D_ADDR 8'h10
`define BTQ_OFF_D_MASK 8'h14
`define BTQ_OFF_PTR 8'h18
`define BTQ_OFF_SRC 8'h1c
`define BTQ_OFF_DST 8'h20

// control register fields
`define BTQ_CTRL_TRACE_EN 0
`define BTQ_CTRL_SEQ_LO 1
`define BTQ_CTRL_SEQ_HI 2
`define BTQ_CTRL_POST_C 3
`define BTQ_CTRL_POST_D 4
`define BTQ_CTRL_W 5
`define BTQ_CTRL_RST 5'h00

// status register fields
`define BTQ_STAT_FLAG_C 0
`define BTQ_STAT_FLAG_D 1
`define BTQ_STAT_LVL_LSB 2

// pointer register: invalid marker bit
`define BTQ_PTR_INV_BIT 31

// queue depth and pointer width defaults
`define BTQ_DEPTH 4
`define BTQ_PTR_W 8

`endif

// ===== include/btq_pkg.sv
package btq_pkg;
	// kind of change of flow reported by the core
	typedef enum logic [1:0] {
		BTQ_COF_BRANCH = 2'b00,
		BTQ_COF_REPEAT = 2'b01,
		BTQ_COF_IRQ = 2'b10
	} btq_cof_kind_t;
endpackage : btq_pkg

// ===== verilog/btq_match.sv
`timescale 1ns/10ps
module btq_match (
	input wire logic [31:0] addr_reg_i,
	input wire logic [31:0] mask_reg_i,
	input wire logic post_i,
	input wire logic issue_i,
	input wire logic [31:0] issue_addr_i,
	input wire logic retire_i,
	input wire logic [31:0] retire_addr_i,
	output logic hit_o
);
	logic [31:0] probe;
	logic strobe;

	// pre-execution breaks look at the instruction entering execution,
	// post-execution breaks at the one that just completed
	always_comb begin
		probe = post_i ? retire_addr_i : issue_addr_i;
		strobe = post_i ? retire_i : issue_i;
		// masked bits take no part in the compare
		hit_o = strobe && (((probe ^ addr_reg_i) & ~mask_reg_i) == 32'h0000_0000);
	end
endmodule : btq_match

// ===== verilog/btq_queue.sv
`timescale 1ns/10ps
`include "btq_consts.svh"
module btq_queue #(
	parameter int DEPTH = `BTQ_DEPTH,
	parameter int PTR_W = `BTQ_PTR_W
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic push_i,
	input wire logic pop_i,
	input wire logic [31:0] src_i,
	input wire logic [31:0] dst_i,
	input wire logic [PTR_W-1:0] ptr_i,
	input wire logic inv_i,
	output logic [31:0] src_o,
	output logic [31:0] dst_o,
	output logic [PTR_W-1:0] ptr_o,
	output logic inv_o,
	output logic [$clog2(DEPTH+1)-1:0] count_o
);
	localparam int CW = $clog2(DEPTH+1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [31:0] src_mem [DEPTH];
	logic [31:0] dst_mem [DEPTH];
	logic [PTR_W-1:0] ptr_mem [DEPTH];
	logic inv_mem [DEPTH];
	logic [CW-1:0] count_reg;

	// entry 0 is the newest record and the head; a push without a pop shifts the rest
	// toward the tail and the tail falls off when full
	genvar i;
	for (i = 0; i < DEPTH; i++) begin : g_ent
		always_ff @(posedge mclk_i) begin
			if (srst_i) begin
				src_mem[i] <= 32'h0000_0000;
				dst_mem[i] <= 32'h0000_0000;
				ptr_mem[i] <= '0;
				inv_mem[i] <= 1'b0;
			end else if (push_i && (i == 0)) begin
				src_mem[i] <= src_i;
				dst_mem[i] <= dst_i;
				ptr_mem[i] <= ptr_i;
				inv_mem[i] <= inv_i;
			end else if (push_i && !pop_i && (i > 0)) begin
				src_mem[i] <= src_mem[(i > 0) ? i-1 : 0];
				dst_mem[i] <= dst_mem[(i > 0) ? i-1 : 0];
				ptr_mem[i] <= ptr_mem[(i > 0) ? i-1 : 0];
				inv_mem[i] <= inv_mem[(i > 0) ? i-1 : 0];
			end else if (pop_i && !push_i) begin
				src_mem[i] <= (i == DEPTH-1) ? 32'h0000_0000 : src_mem[(i < DEPTH-1) ? i+1 : i];
				dst_mem[i] <= (i == DEPTH-1) ? 32'h0000_0000 : dst_mem[(i < DEPTH-1) ? i+1 : i];
				ptr_mem[i] <= (i == DEPTH-1) ? '0 : ptr_mem[(i < DEPTH-1) ? i+1 : i];
				inv_mem[i] <= (i == DEPTH-1) ? 1'b0 : inv_mem[(i < DEPTH-1) ? i+1 : i];
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			count_reg <= '0;
		end else if (push_i && !pop_i && (count_reg != FULL)) begin
			count_reg <= count_reg + 1'b1;
		end else if (pop_i && !push_i && (count_reg != '0)) begin
			count_reg <= count_reg - 1'b1;
		end else if (pop_i && push_i && (count_reg == '0)) begin
			count_reg <= CW'(1);
		end
	end

	assign src_o = src_mem[0];
	assign dst_o = dst_mem[0];
	assign ptr_o = ptr_mem[0];
	assign inv_o = inv_mem[0];
	assign count_o = count_reg;

	a_depth_bound: assert property (@(posedge mclk_i) disable iff (srst_i)
		count_reg <= FULL) else $error("queue holds more than its depth");
	a_keep_newest: assert property (@(posedge mclk_i) disable iff (srst_i)
		push_i && !pop_i && count_reg == FULL |=> count_reg == FULL && src_mem[0] == $past(src_i))
		else $error("full queue did not keep newest record");
endmodule : btq_queue

// ===== verilog/btq_top.sv
// What this block does
// - trace starts when software sets trace enable
// - one record per branch, loop return, interrupt
// - destination holds first fetch at new target
// - source holds last fetch before flow change
// - pointer gives offset to last executed instruction
// - pre-branch address equals source minus twice pointer
// - delayed branch to 4n+2 stores target, pointer invalid
// - source is 4n aligned except that case
// - loop return points at second-last loop instruction
// - interrupt records handler start and last executed
// - loops of three or fewer leave no record
// - records sit in a four-deep queue
// - trace register reads return the queue head
// - destination read advances the queue by one
// - masked address bits are left out of compare
// - post break after, pre break before instruction
// - sequential mode breaks on C then D only
`timescale 1ns/10ps
`include "btq_consts.svh"
module btq_top #(
	parameter int DEPTH = `BTQ_DEPTH,
	parameter int PTR_W = `BTQ_PTR_W
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic fetch_i,
	input wire logic [31:0] fetch_addr_i,
	input wire logic cof_i,
	input wire btq_pkg::btq_cof_kind_t cof_kind_i,
	input wire logic cof_delayed_i,
	input wire logic cof_short_loop_i,
	input wire logic [31:0] cof_target_i,
	input wire logic [31:0] cof_exec_addr_i,
	input wire logic issue_i,
	input wire logic [31:0] issue_addr_i,
	input wire logic retire_i,
	input wire logic [31:0] retire_addr_i,
	output logic break_o
);
	import btq_pkg::*;

	localparam int CW = $clog2(DEPTH+1);

	logic [`BTQ_CTRL_W-1:0] ctrl_reg;
	logic [31:0] c_addr_reg;
	logic [31:0] c_mask_reg;
	logic [31:0] d_addr_reg;
	logic [31:0] d_mask_reg;
	logic flag_c_reg;
	logic flag_d_reg;
	logic c_met_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic break_reg;

	logic [31:0] last_fetch_reg;
	logic pend_reg;
	logic [31:0] src_hold_reg;
	logic [PTR_W-1:0] ptr_hold_reg;
	logic inv_hold_reg;

	logic setup;
	logic done;
	logic wr_done;
	logic rd_dst;
	logic mapped;
	logic [31:0] rd_mux;

	logic trace_en;
	logic seq_cd;
	logic cof_take;
	logic push;
	logic [31:0] src_next;
	logic [31:0] src_in;
	logic [PTR_W-1:0] ptr_next;
	logic [PTR_W-1:0] ptr_in;
	logic inv_next;
	logic inv_in;
	logic [31:0] fetch_aligned;
	logic [31:0] offset;

	logic hit_c;
	logic hit_d;
	logic brk_next;
	logic set_c;
	logic set_d;

	logic [31:0] head_src;
	logic [31:0] head_dst;
	logic [PTR_W-1:0] head_ptr;
	logic head_inv;
	logic [CW-1:0] level;

	// apb slave
	assign setup = psel_i && !penable_i;
	assign done = psel_i && penable_i && pready_reg;
	assign wr_done = done && pwrite_i && !pslverr_reg;
	assign rd_dst = done && !pwrite_i && (paddr_i == `BTQ_OFF_DST);

	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (paddr_i)
			`BTQ_OFF_CTRL: rd_mux = {{(32-`BTQ_CTRL_W){1'b0}}, ctrl_reg};
			`BTQ_OFF_STAT: rd_mux = {{(30-CW){1'b0}}, level, flag_d_reg, flag_c_reg};
			`BTQ_OFF_C_ADDR: rd_mux = c_addr_reg;
			`BTQ_OFF_C_MASK: rd_mux = c_mask_reg;
			`BTQ_OFF_D_ADDR: rd_mux = d_addr_reg;
			`BTQ_OFF_D_MASK: rd_mux = d_mask_reg;
			// head record fields; invalid marker on top of the pointer
			`BTQ_OFF_PTR: rd_mux = {head_inv, {(31-PTR_W){1'b0}}, head_ptr};
			`BTQ_OFF_SRC: rd_mux = head_src;
			`BTQ_OFF_DST: rd_mux = head_dst;
			default: mapped = 1'b0;
		endcase
	end

	// no wait state: the answer is prepared in the setup cycle
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else if (setup) begin
			pready_reg <= 1'b1;
			pslverr_reg <= !mapped;
			prdata_reg <= pwrite_i ? 32'h0000_0000 : rd_mux;
		end else begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			ctrl_reg <= `BTQ_CTRL_RST;
			c_addr_reg <= 32'h0000_0000;
			c_mask_reg <= 32'h0000_0000;
			d_addr_reg <= 32'h0000_0000;
			d_mask_reg <= 32'h0000_0000;
		end else if (wr_done) begin
			unique case (paddr_i)
				`BTQ_OFF_CTRL: ctrl_reg <= pwdata_i[`BTQ_CTRL_W-1:0];
				`BTQ_OFF_C_ADDR: c_addr_reg <= pwdata_i;
				`BTQ_OFF_C_MASK: c_mask_reg <= pwdata_i;
				`BTQ_OFF_D_ADDR: d_addr_reg <= pwdata_i;
				`BTQ_OFF_D_MASK: d_mask_reg <= pwdata_i;
				default: ;
			endcase
		end
	end

	// branch trace capture
	assign trace_en = ctrl_reg[`BTQ_CTRL_TRACE_EN];
	// loops this short issue no fetch at the return, so nothing to record
	assign cof_take = trace_en && cof_i
		&& !(cof_kind_i == BTQ_COF_REPEAT && cof_short_loop_i);
	assign fetch_aligned = {last_fetch_reg[31:2], 2'b00};
	// exec address is the branch itself, the second-last loop
	// instruction, or the last one before an interrupt
	assign offset = fetch_aligned - cof_exec_addr_i;

	always_comb begin
		if (cof_delayed_i && cof_target_i[1]) begin
			src_next = cof_target_i;
			ptr_next = '0;
			inv_next = 1'b1;
		end else begin
			src_next = fetch_aligned;
			ptr_next = offset[PTR_W:1];
			inv_next = 1'b0;
		end
	end

	assign push = fetch_i && (pend_reg || cof_take);
	assign src_in = cof_take ? src_next : src_hold_reg;
	assign ptr_in = cof_take ? ptr_next : ptr_hold_reg;
	assign inv_in = cof_take ? inv_next : inv_hold_reg;

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			last_fetch_reg <= 32'h0000_0000;
		end else if (fetch_i) begin
			last_fetch_reg <= fetch_addr_i;
		end
	end

	// a flow change waits here until the first fetch at the target
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			pend_reg <= 1'b0;
			src_hold_reg <= 32'h0000_0000;
			ptr_hold_reg <= '0;
			inv_hold_reg <= 1'b0;
		end else begin
			if (cof_take) begin
				src_hold_reg <= src_next;
				ptr_hold_reg <= ptr_next;
				inv_hold_reg <= inv_next;
			end
			if (!trace_en || fetch_i) begin
				pend_reg <= 1'b0;
			end else if (cof_take) begin
				pend_reg <= 1'b1;
			end
		end
	end

	btq_queue #(
		.DEPTH(DEPTH),
		.PTR_W(PTR_W)
	) u_queue (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.push_i(push),
		.pop_i(rd_dst),
		.src_i(src_in),
		.dst_i(fetch_addr_i),
		.ptr_i(ptr_in),
		.inv_i(inv_in),
		.src_o(head_src),
		.dst_o(head_dst),
		.ptr_o(head_ptr),
		.inv_o(head_inv),
		.count_o(level)
	);

	// address break channels
	btq_match u_match_c (
		.addr_reg_i(c_addr_reg),
		.mask_reg_i(c_mask_reg),
		.post_i(ctrl_reg[`BTQ_CTRL_POST_C]),
		.issue_i(issue_i),
		.issue_addr_i(issue_addr_i),
		.retire_i(retire_i),
		.retire_addr_i(retire_addr_i),
		.hit_o(hit_c)
	);

	btq_match u_match_d (
		.addr_reg_i(d_addr_reg),
		.mask_reg_i(d_mask_reg),
		.post_i(ctrl_reg[`BTQ_CTRL_POST_D]),
		.issue_i(issue_i),
		.issue_addr_i(issue_addr_i),
		.retire_i(retire_i),
		.retire_addr_i(retire_addr_i),
		.hit_o(hit_d)
	);

	assign seq_cd = ctrl_reg[`BTQ_CTRL_SEQ_LO] && !ctrl_reg[`BTQ_CTRL_SEQ_HI];

	// in sequential mode, simultaneous C and D hits count as C alone unless C already met
	always_comb begin
		if (seq_cd) begin
			brk_next = hit_d && c_met_reg;
			set_c = hit_c && !(hit_d && c_met_reg);
			set_d = hit_d && c_met_reg;
		end else begin
			brk_next = hit_c || hit_d;
			set_c = hit_c;
			set_d = hit_d;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i || !seq_cd) begin
			c_met_reg <= 1'b0;
		end else if (hit_d && c_met_reg) begin
			c_met_reg <= 1'b0;
		end else if (hit_c) begin
			c_met_reg <= 1'b1;
		end
	end

	// write one to clear; a new hit in the same cycle wins
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			flag_c_reg <= 1'b0;
			flag_d_reg <= 1'b0;
		end else begin
			flag_c_reg <= set_c || (flag_c_reg
				&& !(wr_done && paddr_i == `BTQ_OFF_STAT && pwdata_i[`BTQ_STAT_FLAG_C]));
			flag_d_reg <= set_d || (flag_d_reg
				&& !(wr_done && paddr_i == `BTQ_OFF_STAT && pwdata_i[`BTQ_STAT_FLAG_D]));
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			break_reg <= 1'b0;
		end else begin
			break_reg <= brk_next;
		end
	end

	assign prdata_o = prdata_reg;
	assign pready_o = pready_reg;
	assign pslverr_o = pslverr_reg;
	assign break_o = break_reg;

	// checks
	a_trace_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
		!trace_en && !pend_reg |-> !push) else $error("record taken while trace off");
	a_dest_value: assert property (@(posedge mclk_i) disable iff (srst_i)
		push |=> head_dst == $past(fetch_addr_i))
		else $error("destination is not the target fetch");
	a_src_align: assert property (@(posedge mclk_i) disable iff (srst_i)
		push && !inv_in |-> src_in[1:0] == 2'b00)
		else $error("source not longword aligned");
	a_delay_target: assert property (@(posedge mclk_i) disable iff (srst_i)
		cof_take && cof_delayed_i && cof_target_i[1] |-> src_next == cof_target_i && inv_next)
		else $error("delayed 4n+2 target not stored as source");
	a_ptr_relation: assert property (@(posedge mclk_i) disable iff (srst_i)
		cof_take && !inv_next |->
			(src_next[PTR_W:0] - {ptr_next, 1'b0}) == {cof_exec_addr_i[PTR_W:1], 1'b0})
		else $error("pointer does not lead back to executed instruction");
	a_short_loop: assert property (@(posedge mclk_i) disable iff (srst_i)
		cof_i && cof_kind_i == BTQ_COF_REPEAT && cof_short_loop_i |-> !cof_take)
		else $error("short loop produced a record");
	a_dst_pops: assert property (@(posedge mclk_i) disable iff (srst_i)
		rd_dst && !push && level != '0 |=> level == $past(level) - 1'b1)
		else $error("destination read did not advance queue");
	a_seq_order: assert property (@(posedge mclk_i) disable iff (srst_i)
		seq_cd && hit_d && !c_met_reg |=> !break_reg)
		else $error("sequential break without channel C first");
	// recomputes the channel C pre-execution compare from the raw inputs
	a_break_timing: assert property (@(posedge mclk_i) disable iff (srst_i)
		!seq_cd && issue_i && !ctrl_reg[`BTQ_CTRL_POST_C]
		&& (((issue_addr_i ^ c_addr_reg) & ~c_mask_reg) == 32'h0000_0000) |=> break_reg)
		else $error("break not raised one cycle after match");
endmodule : btq_top

// ===== tb/btq_core_model.sv
`timescale 1ns/10ps
module btq_core_model (
	input wire logic mclk_i,
	output logic fetch_o,
	output logic [31:0] fetch_addr_o,
	output logic cof_o,
	output btq_pkg::btq_cof_kind_t cof_kind_o,
	output logic cof_delayed_o,
	output logic cof_short_loop_o,
	output logic [31:0] cof_target_o,
	output logic [31:0] cof_exec_addr_o,
	output logic issue_o,
	output logic [31:0] issue_addr_o,
	output logic retire_o,
	output logic [31:0] retire_addr_o
);
	import btq_pkg::*;
	initial begin
		{fetch_o, cof_o, cof_delayed_o, cof_short_loop_o, issue_o, retire_o} = 6'h00;
		{fetch_addr_o, cof_target_o, cof_exec_addr_o, issue_addr_o, retire_addr_o} = '0;
		cof_kind_o = BTQ_COF_BRANCH;
	end
	// idle address lines show the inverse so stale values never match
	task automatic fetch(input logic [31:0] a);
		@(posedge mclk_i);
		fetch_o <= 1'b1;
		fetch_addr_o <= a;
		@(posedge mclk_i);
		fetch_o <= 1'b0;
		fetch_addr_o <= ~a;
	endtask : fetch
	// last fetch, then the flow change, then the first target fetch
	task automatic change(input btq_cof_kind_t k, input logic d, input logic s,
		input logic [31:0] last, input logic [31:0] ex, input logic [31:0] tg);
		fetch(last);
		@(posedge mclk_i);
		cof_o <= 1'b1;
		cof_kind_o <= k;
		cof_delayed_o <= d;
		cof_short_loop_o <= s;
		cof_exec_addr_o <= ex;
		cof_target_o <= tg;
		@(posedge mclk_i);
		cof_o <= 1'b0;
		cof_exec_addr_o <= ~ex;
		cof_target_o <= ~tg;
		fetch(tg);
	endtask : change
	// post selects a completed instruction, otherwise one about to run
	task automatic exec_ev(input logic post, input logic [31:0] a);
		@(posedge mclk_i);
		issue_o <= ~post;
		retire_o <= post;
		issue_addr_o <= a;
		retire_addr_o <= a;
		@(posedge mclk_i);
		{issue_o, retire_o} <= 2'b00;
		issue_addr_o <= ~a;
		retire_addr_o <= ~a;
	endtask : exec_ev
endmodule : btq_core_model

// ===== tb/btq_top_tb.sv
`timescale 1ns/10ps
`include "btq_consts.svh"
module btq_top_tb;
	import btq_pkg::*;
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd, fa, tg, ex, iss_a, ra;
	logic pready, pslverr, se, brk, fe, cof, dly, shrt, iss, ret;
	btq_cof_kind_t kind;
	int miscompares = 0;
	int checks_done = 0;
	int brk_cnt = 0;
	int ebrk = 0;
	always #4 mclk_i = ~mclk_i;
	always @(posedge mclk_i) if (brk === 1'b1) brk_cnt <= brk_cnt + 1;
	btq_top i_btq_top (.mclk_i(mclk_i), .srst_i(srst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .fetch_i(fe),
		.fetch_addr_i(fa), .cof_i(cof), .cof_kind_i(kind), .cof_delayed_i(dly),
		.cof_short_loop_i(shrt), .cof_target_i(tg), .cof_exec_addr_i(ex),
		.issue_i(iss), .issue_addr_i(iss_a), .retire_i(ret), .retire_addr_i(ra),
		.break_o(brk));
	btq_core_model i_btq_core_model (.mclk_i(mclk_i), .fetch_o(fe), .fetch_addr_o(fa),
		.cof_o(cof), .cof_kind_o(kind), .cof_delayed_o(dly), .cof_short_loop_o(shrt),
		.cof_target_o(tg), .cof_exec_addr_o(ex), .issue_o(iss), .issue_addr_o(iss_a),
		.retire_o(ret), .retire_addr_o(ra));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		// hold the request until pready is seen high at a rising edge
		do @(posedge mclk_i); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rd_chk
	task automatic rec(input logic [31:0] p, input logic [31:0] s, input logic [31:0] d);
		rd_chk(`BTQ_OFF_PTR, p);
		rd_chk(`BTQ_OFF_SRC, s);
		rd_chk(`BTQ_OFF_DST, d);
	endtask : rec
	task automatic brk_chk(input logic post, input logic [31:0] a, input int n);
		i_btq_core_model.exec_ev(post, a);
		repeat (3) @(posedge mclk_i);
		@(negedge mclk_i);
		ebrk += n;
		chk(32'(brk_cnt), 32'(ebrk));
	endtask : brk_chk
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (20000) @(posedge mclk_i);
		$display("MISMATCH %0t watchdog expired", $time);
		miscompares++;
		complete_run();
	end
	initial begin
		repeat (3) @(posedge mclk_i);
		srst_i <= 1'b0;
		rd_chk(`BTQ_OFF_CTRL, 32'h0);
		rd_chk(`BTQ_OFF_STAT, 32'h0);
		rec(32'h0, 32'h0, 32'h0);
		rd_chk(8'h24, 32'h0);
		chk(32'(se), 32'h1);
		$display("test reset done");
		i_btq_core_model.change(BTQ_COF_BRANCH, 1'b0, 1'b0, 32'h1006, 32'h1002, 32'h2000);
		rd_chk(`BTQ_OFF_STAT, 32'h0);
		apb(1'b1, `BTQ_OFF_CTRL, 32'h1);
		i_btq_core_model.change(BTQ_COF_BRANCH, 1'b0, 1'b0, 32'h1006, 32'h1002, 32'h2000);
		i_btq_core_model.change(BTQ_COF_BRANCH, 1'b1, 1'b0, 32'h2ffe, 32'h2ffc, 32'h3002);
		i_btq_core_model.change(BTQ_COF_REPEAT, 1'b0, 1'b0, 32'h4014, 32'h4010, 32'h4000);
		i_btq_core_model.change(BTQ_COF_IRQ, 1'b0, 1'b0, 32'h5008, 32'h5000, 32'h6000);
		i_btq_core_model.change(BTQ_COF_REPEAT, 1'b0, 1'b1, 32'h8008, 32'h8004, 32'h8000);
		i_btq_core_model.change(BTQ_COF_BRANCH, 1'b1, 1'b0, 32'h6ffe, 32'h6ffa, 32'h7000);
		rd_chk(`BTQ_OFF_STAT, 32'h10);
		rec(32'h1, 32'h6ffc, 32'h7000);
		rd_chk(`BTQ_OFF_STAT, 32'hc);
		rec(32'h4, 32'h5008, 32'h6000);
		rec(32'h2, 32'h4014, 32'h4000);
		rec(32'h80000000, 32'h3002, 32'h3002);
		rd_chk(`BTQ_OFF_STAT, 32'h0);
		$display("test trace queue done");
		apb(1'b1, `BTQ_OFF_CTRL, 32'h10);
		apb(1'b1, `BTQ_OFF_C_ADDR, 32'h3080);
		apb(1'b1, `BTQ_OFF_C_MASK, 32'h7f);
		apb(1'b1, `BTQ_OFF_D_ADDR, 32'h404);
		brk_chk(1'b0, 32'h30ff, 1);
		brk_chk(1'b0, 32'h3100, 0);
		brk_chk(1'b0, 32'h404, 0);
		brk_chk(1'b1, 32'h404, 1);
		apb(1'b1, `BTQ_OFF_CTRL, 32'h12);
		rd_chk(`BTQ_OFF_CTRL, 32'h12);
		brk_chk(1'b1, 32'h404, 0);
		brk_chk(1'b0, 32'h3080, 0);
		brk_chk(1'b1, 32'h404, 1);
		// post-execution channel C and pre-execution channel D, seq code 1x independent
		apb(1'b1, `BTQ_OFF_CTRL, 32'h0c);
		brk_chk(1'b1, 32'h3080, 1);
		brk_chk(1'b0, 32'h404, 1);
		brk_chk(1'b0, 32'h3080, 0);
		// both match flags were set by earlier hits; write one clears them
		rd_chk(`BTQ_OFF_STAT, 32'h3);
		apb(1'b1, `BTQ_OFF_STAT, 32'h3);
		rd_chk(`BTQ_OFF_STAT, 32'h0);
		$display("test break match done");
		complete_run();
	end
endmodule : btq_top_tb
